// *** i2c_link_pkg.sv ***
// shared constants for the two-wire regulator configuration link
package i2c_link_pkg;
  localparam logic [6:0] target_addr = 7'h18;     // 001 1000
  localparam logic [6:0] general_call = 7'h00;
  localparam logic [4:0] hs_code_top = 5'h01;     // master code 00001xxx
  localparam int bits_per_byte = 8;
  localparam logic [3:0] ack_slot = 4'h8;         // ninth bit, counted from zero
  localparam int ptr_w = 8;
  localparam int data_w = 8;
  localparam int clk_period_ns = 4;
  localparam int scl_half_ns = 32;                // controller phase time at default, half of an scl half period
  localparam int scl_half_cyc = (scl_half_ns + clk_period_ns - 1) / clk_period_ns;
endpackage

// *** i2c_link_if.sv ***
// two-wire bus carrier: open-drain wired-and of both ends on data, clock driven by the controller only
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_ctl_oe; // controller pulls scl low
  logic sda_ctl_oe; // controller pulls sda low
  logic sda_tgt_oe; // target pulls sda low
  logic scl;        // resolved clock line
  logic sda;        // resolved data line
  assign scl = ~scl_ctl_oe;
  assign sda = ~(sda_ctl_oe | sda_tgt_oe);
  modport target (input scl, input sda, output sda_tgt_oe);
  modport controller (input scl, input sda, output scl_ctl_oe, output sda_ctl_oe);
endinterface // i2c_link_if

// *** i2c_target.sv ***
// two-wire target port of the regulator: address match, acks, register write and read
// Overview of operation
// RULE_01: one bit per clock, data stable while high
// RULE_02: decode start and stop on data edges
// RULE_03: repeated start restarts address reception
// RULE_04: after stop or mismatch ignore clocks
// RULE_05: ack is data low over ninth clock
// RULE_06: nack leaves data high on ninth clock
// RULE_07: receiver of each byte sends the ack
// RULE_08: controller retries after an unacknowledged transfer; i2c_controller only raises nacked and stops, it does not retry
// RULE_09: answer only address 0x18 (0x30/0x31)
// RULE_10: never hold the clock line low
// RULE_11: general call gets no acknowledge
// RULE_12: work at any rate up to 3.4MHz
// RULE_13: filters normal speed at reset and stop
// RULE_14: high speed filters only after master code
// RULE_15: repeated start keeps the filter setting
// RULE_16: write is address, pointer, data, each acked
// RULE_17: load data at rising ack clock edge
// RULE_18: further data go to next registers
// RULE_19: ack every write data byte, last included
// RULE_20: read returns pointer data, ack asks more
// RULE_21: master code byte is not acknowledged
// RULE_22: synchronise lines, detect edges internally
`timescale 1ns/1ps
module i2c_target
  import i2c_link_pkg::*;
(
  input wire logic ref_clk,                              // system clock
  input wire logic rst,                                  // synchronous reset, high
  i2c_link_if.target bus,                                // two-wire bus
  output logic wr_stb,                                   // one-cycle register write strobe
  output logic [i2c_link_pkg::ptr_w-1:0] wr_addr,        // register written
  output logic [i2c_link_pkg::data_w-1:0] wr_data,       // value written
  output logic [i2c_link_pkg::ptr_w-1:0] rd_addr,        // register to be read
  input wire logic [i2c_link_pkg::data_w-1:0] rd_data,   // read value, same clock
  output logic hs_filter                                 // high-speed input filter selected
);
  import i2c_link_pkg::*;

  typedef enum {st_idle, st_addr, st_ptr, st_wdata, st_rdata, st_mcode} tgt_state_t;

  logic [1:0] scl_s, sda_s;
  logic scl_d, sda_d;
  // two-stage synchronisers; only stage two feeds logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], bus.scl};                     // RULE_22
      sda_s <= {sda_s[0], bus.sda};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  wire logic scl_q = scl_s[1];
  wire logic sda_q = sda_s[1];
  wire logic scl_rise = scl_q & ~scl_d;                 // RULE_01
  wire logic scl_fall = ~scl_q & scl_d;
  wire logic start_ev = scl_q & scl_d & sda_d & ~sda_q; // RULE_02
  wire logic stop_ev = scl_q & scl_d & ~sda_d & sda_q;  // RULE_02

  tgt_state_t state, next_state;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg;
  logic [ptr_w-1:0] ptr, next_ptr;
  logic reading, next_reading;
  logic drive, next_drive;
  logic acking, next_acking;
  logic hs, next_hs;
  logic stb, next_stb;
  logic [data_w-1:0] wdat, next_wdat;
  logic [ptr_w-1:0] waddr, next_waddr;

  // protocol engine; samples on clock rise, drives data after clock fall
  always_comb begin
    next_state = state;
    next_bitn = bitn;
    next_shreg = shreg;
    next_ptr = ptr;
    next_reading = reading;
    next_drive = drive;
    next_acking = acking;
    next_hs = hs;
    next_stb = 1'b0;
    next_wdat = wdat;
    next_waddr = waddr;
    if (stop_ev) begin
      next_state = st_idle;                             // RULE_04
      next_drive = 1'b0;
      next_hs = 1'b0;                                   // RULE_13
    end else if (start_ev) begin
      next_state = st_addr;                             // RULE_03 RULE_15
      next_bitn = 4'hf;                                 // the clock fall that ends a start carries no bit
      next_drive = 1'b0;
      next_acking = 1'b0;
    end else if (state != st_idle) begin
      if (scl_rise) begin
        if (bitn == ack_slot) begin
          // ninth clock: receiver's ack
          if (state == st_wdata && acking) begin
            next_stb = 1'b1;                            // RULE_17
            next_waddr = ptr;
            next_wdat = shreg;
            next_ptr = ptr + 8'h01;                     // RULE_18
          end
          if (state == st_rdata) begin
            next_ptr = ptr + 8'h01;
            if (sda_q) next_state = st_idle;            // RULE_20 RULE_06
          end
          if (state == st_mcode) next_state = st_idle;  // RULE_14
        end else if (state != st_rdata) begin
          // a byte being sent shifts on clock fall only, never twice per bit
          next_shreg = {shreg[6:0], sda_q};
        end
      end else if (scl_fall) begin
        if (bitn == ack_slot) begin
          next_bitn = 4'h0;
          next_drive = 1'b0;
          next_acking = 1'b0;
          // state moves on after the ack clock, so the ack rise still sees the byte's own phase
          if (state == st_addr) next_state = reading ? st_rdata : st_ptr;
          if (state == st_ptr) next_state = st_wdata;   // RULE_16
          if (state == st_rdata || (state == st_addr && reading)) begin
            next_shreg = rd_data;
            next_drive = ~rd_data[7];                   // RULE_07
          end
        end else begin
          next_bitn = bitn + 4'h1;
          if (state == st_rdata) begin
            next_drive = (bitn == 4'h7) ? 1'b0 : ~shreg[6];
            next_shreg = {shreg[6:0], 1'b1};
          end
          if (bitn == 4'h7) begin
            // byte complete: decide the ack
            case (state)
              st_addr: begin
                if (shreg[7:3] == hs_code_top) begin
                  next_state = st_mcode;                // RULE_21
                  next_hs = 1'b1;                       // RULE_14
                end else if (shreg[7:1] == target_addr) begin // RULE_09
                  next_acking = 1'b1;
                  next_drive = 1'b1;                    // RULE_05
                  next_reading = shreg[0];
                end else begin
                  next_state = st_idle;                 // RULE_04 RULE_11
                end
              end
              st_ptr: begin
                next_ptr = shreg;
                next_acking = 1'b1;
                next_drive = 1'b1;
              end
              st_wdata: begin
                next_acking = 1'b1;
                next_drive = 1'b1;                      // RULE_19
              end
              default: begin
                next_acking = 1'b0;
              end
            endcase
          end
        end
      end
    end
  end

  // after an acked read address the first data bit goes out on the ack clock fall
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= st_idle;
      bitn <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      reading <= 1'b0;
      drive <= 1'b0;
      acking <= 1'b0;
      hs <= 1'b0;                                       // RULE_13
      stb <= 1'b0;
      wdat <= 8'h00;
      waddr <= 8'h00;
    end else begin
      state <= next_state;
      bitn <= next_bitn;
      shreg <= next_shreg;
      ptr <= next_ptr;
      reading <= next_reading;
      drive <= next_drive;
      acking <= next_acking;
      hs <= next_hs;
      stb <= next_stb;
      wdat <= next_wdat;
      waddr <= next_waddr;
    end
  end

  // scl is input only: no stretching is possible
  assign bus.sda_tgt_oe = drive;                        // RULE_10
  assign wr_stb = stb;
  assign wr_addr = waddr;
  assign wr_data = wdat;
  assign rd_addr = ptr;
  assign hs_filter = hs;                                // RULE_12
endmodule // i2c_target

// *** i2c_controller.sv ***
// two-wire bus controller end: one command per transfer, write or read
`timescale 1ns/1ps
module i2c_controller
  import i2c_link_pkg::*;
#(
  parameter int half_cyc = i2c_link_pkg::scl_half_cyc   // clocks per controller phase; two phases make an scl half period
) (
  input wire logic ref_clk,                             // system clock
  input wire logic rst,                                 // synchronous reset, high
  i2c_link_if.controller bus,                           // two-wire bus
  input wire logic cmd_valid,                           // start a transfer, one cycle
  input wire logic cmd_read,                            // 1 read, 0 write
  input wire logic [7:0] cmd_ptr,                       // register pointer
  input wire logic [7:0] cmd_wdata,                     // data for a write
  output logic busy,                                    // transfer in progress
  output logic done,                                    // one-cycle end pulse
  output logic nacked,                                  // target failed to ack, retry later
  output logic [7:0] rdata                              // byte read
);
  import i2c_link_pkg::*;

  typedef enum {c_idle, c_start, c_byte, c_rstart, c_stop} ctl_state_t;

  ctl_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [1:0] ph, next_ph;
  logic [3:0] bitn, next_bitn;
  logic [2:0] byten, next_byten;
  logic [7:0] sh, next_sh;
  logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic rd, next_rd, nk, next_nk, dn, next_dn;
  logic bsy, next_bsy;
  logic [7:0] p, next_p, wd, next_wd, rv, next_rv;
  logic sda_s1, sda_s2;

  // data line synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // bytes: 0 addr+w, 1 ptr, 2 data or (read) 2 addr+r, 3 data in
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ph = ph;
    next_bitn = bitn;
    next_byten = byten;
    next_sh = sh;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_rd = rd;
    next_nk = nk;
    next_dn = 1'b0;
    next_p = p;
    next_wd = wd;
    next_rv = rv;
    if (state == c_idle) begin
      if (cmd_valid) begin
        next_state = c_start;
        next_rd = cmd_read;
        next_p = cmd_ptr;
        next_wd = cmd_wdata;
        next_nk = 1'b0;
        next_cnt = 8'h00;
        next_ph = 2'h0;
      end
    end else if (cnt != 8'(half_cyc - 1)) begin
      next_cnt = cnt + 8'h01;
    end else begin
      next_cnt = 8'h00;
      next_ph = ph + 2'h1;
      case (state)
        c_start, c_rstart: begin
          // ph0 release sda, ph1 release scl, ph2 pull sda, ph3 pull scl
          case (ph)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            default: begin
              next_scl_oe = 1'b1;
              next_state = c_byte;
              next_bitn = 4'h0;
              next_ph = 2'h0;
              if (state == c_start) begin
                next_byten = 3'h0;
                next_sh = {target_addr, 1'b0};
              end else begin
                next_byten = 3'h2;
                next_sh = {target_addr, 1'b1};
              end
            end
          endcase
        end
        c_byte: begin
          // ph0 set sda while low, ph1 raise scl, ph2 sample, ph3 lower
          case (ph)
            2'h0: begin
              if (bitn == ack_slot)
                next_sda_oe = (rd && byten == 3'h3) ? 1'b0 : 1'b0; // single read ends with nack
              else if (rd && byten == 3'h3)
                next_sda_oe = 1'b0;
              else
                next_sda_oe = ~sh[7];
              if (bitn == ack_slot && !(rd && byten == 3'h3)) next_sda_oe = 1'b0;
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn == ack_slot) begin
                if (!(rd && byten == 3'h3) && sda_s2) next_nk = 1'b1; // RULE_08
              end else begin
                next_sh = {sh[6:0], sda_s2};
              end
            end
            default: begin
              next_scl_oe = 1'b1;
              next_ph = 2'h0;
              if (bitn != ack_slot) begin
                next_bitn = bitn + 4'h1;
              end else begin
                next_bitn = 4'h0;
                if (rd && byten == 3'h3) next_rv = sh;
                if (nk || byten == 3'h3 || (!rd && byten == 3'h2)) begin
                  next_state = c_stop;
                end else if (rd && byten == 3'h1) begin
                  next_state = c_rstart;
                end else begin
                  next_byten = byten + 3'h1;
                  next_sh = (byten == 3'h0) ? p : (byten == 3'h1) ? wd : 8'hff;
                end
              end
            end
          endcase
        end
        c_stop: begin
          // ph0 pull sda, ph1 release scl, ph2 release sda
          case (ph)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              next_sda_oe = 1'b0;
              next_state = c_idle;
              next_dn = 1'b1;
            end
            default: next_state = c_idle;
          endcase
        end
        default: next_state = c_idle;
      endcase
    end
    next_bsy = (next_state != c_idle);
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= c_idle;
      cnt <= 8'h00;
      ph <= 2'h0;
      bitn <= 4'h0;
      byten <= 3'h0;
      sh <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rd <= 1'b0;
      nk <= 1'b0;
      dn <= 1'b0;
      bsy <= 1'b0;
      p <= 8'h00;
      wd <= 8'h00;
      rv <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ph <= next_ph;
      bitn <= next_bitn;
      byten <= next_byten;
      sh <= next_sh;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      rd <= next_rd;
      nk <= next_nk;
      dn <= next_dn;
      bsy <= next_bsy;
      p <= next_p;
      wd <= next_wd;
      rv <= next_rv;
    end
  end

  assign bus.scl_ctl_oe = scl_oe;
  assign bus.sda_ctl_oe = sda_oe;
  assign busy = bsy;
  assign done = dn;
  assign nacked = nk;
  assign rdata = rv;
endmodule // i2c_controller

// *** i2c_link_props.sv ***
// concurrent checks on the two-wire link between the controller and the target
`timescale 1ns/1ps
module i2c_link_props
  import i2c_link_pkg::*;
(
  input wire logic ref_clk,    // system clock
  input wire logic rst,        // synchronous reset, high
  input wire logic scl_ctl_oe, // controller pulls clock low
  input wire logic sda_ctl_oe, // controller pulls data low
  input wire logic sda_tgt_oe, // target pulls data low
  input wire logic scl,        // resolved clock line
  input wire logic sda         // resolved data line
);
  logic scl_q, sda_q, first, addressed, reading, ignore;
  logic next_first, next_addressed, next_reading, next_ignore;
  logic [3:0] bit_n, next_bit_n;
  logic [7:0] shreg, next_shreg;
  logic rise, start, stop, ack_rise;
  // events on the raw lines; the target sees them a few clocks later through its synchroniser
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign ack_rise = rise && (bit_n == 4'h8);
  // bus observer: bit position, first byte of a transfer, direction and idle state
  always_comb begin
    next_bit_n = bit_n;
    next_shreg = shreg;
    next_first = first;
    next_addressed = addressed;
    next_reading = reading;
    next_ignore = ignore;
    if (start) begin
      next_bit_n = 4'h0;
      next_first = 1'b1;
      next_addressed = 1'b0;
      next_ignore = 1'b0;
    end else if (stop) begin
      next_ignore = 1'b1;
    end else if (ack_rise) begin
      next_bit_n = 4'h0;
      next_first = 1'b0;
      if (first) begin
        next_addressed = (shreg[7:1] == target_addr);
        next_reading = shreg[0];
        next_ignore = (shreg[7:1] != target_addr);
      end
    end else if (rise) begin
      next_bit_n = bit_n + 4'h1;
      next_shreg = {shreg[6:0], sda};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_n <= 4'h0;
      shreg <= 8'h00;
      first <= 1'b0;
      addressed <= 1'b0;
      reading <= 1'b0;
      ignore <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      bit_n <= next_bit_n;
      shreg <= next_shreg;
      first <= next_first;
      addressed <= next_addressed;
      reading <= next_reading;
      ignore <= next_ignore;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_tgt_hold; $changed(sda_tgt_oe) |-> !scl; endproperty
  a_tgt_hold: assert property (p_tgt_hold) else $error("target data moved while clock high");
  property p_rel_reset; $fell(rst) |-> !sda_tgt_oe && !sda_ctl_oe && !scl_ctl_oe; endproperty
  a_rel_reset: assert property (p_rel_reset) else $error("line held after reset");
  property p_addr_ack; ack_rise && first && (shreg[7:1] == target_addr) |-> !sda && sda_tgt_oe; endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
  property p_data_ack; ack_rise && !first && addressed && !reading |-> !sda; endproperty
  a_data_ack: assert property (p_data_ack) else $error("written byte not acknowledged");
  property p_read_release; ack_rise && !first && reading |-> !sda_tgt_oe; endproperty
  a_read_release: assert property (p_read_release) else $error("target drove controller ack slot");
  property p_addr_quiet; rise && first && (bit_n != 4'h8) |-> !sda_tgt_oe; endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("target drove during address byte");
  property p_ignore_quiet; ignore |-> !sda_tgt_oe; endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("target drove while bus idle");
  property p_ack_release; ack_rise && !first && !reading |-> ##[1:40] !sda_tgt_oe; endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");
endmodule // i2c_link_props

// *** testbench.sv ***
// self-checking bench: controller joined to a target, plus a hand-driven link to a second target
`timescale 1ns/1ps
module testbench;
  import i2c_link_pkg::*;
  typedef struct packed {logic rd; logic [7:0] ptr; logic [7:0] wd;} row_t;
  localparam logic [7:0] rd_key = 8'ha5; // register model: value is address xor key
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic busy, done, nacked, wr_stb, wr_stb2, hs_filter, hs_filter2, ra;
  logic [7:0] rdata, wr_addr, wr_data, rd_addr, wr_addr2, wr_data2, rd_addr2, rv;
  logic [15:0] wq[$];
  logic [15:0] wq2[$];
  int n_errors = 0;
  int checks = 0;
  row_t rows [5] = '{'{1'b0, 8'h00, 8'h12}, '{1'b0, 8'hff, 8'h81}, '{1'b1, 8'h03, 8'h00},
                     '{1'b1, 8'hff, 8'h00}, '{1'b0, 8'h05, 8'h00}};
  i2c_link_if lnk();
  i2c_link_if lnk2();
  i2c_controller i2c_controller_i (.ref_clk(ref_clk), .rst(rst), .bus(lnk.controller), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .busy(busy), .done(done), .nacked(nacked),
    .rdata(rdata));
  i2c_target i2c_target_i (.ref_clk(ref_clk), .rst(rst), .bus(lnk.target), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_addr ^ rd_key), .hs_filter(hs_filter));
  i2c_target i2c_target_i2 (.ref_clk(ref_clk), .rst(rst), .bus(lnk2.target), .wr_stb(wr_stb2), .wr_addr(wr_addr2),
    .wr_data(wr_data2), .rd_addr(rd_addr2), .rd_data(rd_addr2 ^ rd_key), .hs_filter(hs_filter2));
  i2c_link_props i2c_link_props_i (.ref_clk(ref_clk), .rst(rst), .scl_ctl_oe(lnk.scl_ctl_oe),
    .sda_ctl_oe(lnk.sda_ctl_oe), .sda_tgt_oe(lnk.sda_tgt_oe), .scl(lnk.scl), .sda(lnk.sda));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // register writes as seen by the regulator side of each target
  always @(posedge ref_clk) begin
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    if (wr_stb2 === 1'b1) wq2.push_back({wr_addr2, wr_data2});
  end
  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // hand-driven controller on the second link: 16 clocks per bit gives the 64 ns link period
  task automatic bb_bit(input logic b, output logic r);
    lnk2.sda_ctl_oe = ~b;
    cyc(4);
    lnk2.scl_ctl_oe = 1'b0;
    cyc(8);
    r = lnk2.sda;
    lnk2.scl_ctl_oe = 1'b1;
    cyc(4);
  endtask
  task automatic bb_byte(input logic [7:0] v, input logic a, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bb_bit(v[i], r[i]);
    bb_bit(a, ack);
  endtask
  // works from idle and, as a repeated start, from a low clock
  task automatic bb_start;
    lnk2.sda_ctl_oe = 1'b0;
    cyc(4);
    lnk2.scl_ctl_oe = 1'b0;
    cyc(8);
    lnk2.sda_ctl_oe = 1'b1;
    cyc(8);
    lnk2.scl_ctl_oe = 1'b1;
    cyc(4);
  endtask
  task automatic bb_stop;
    lnk2.sda_ctl_oe = 1'b1;
    cyc(4);
    lnk2.scl_ctl_oe = 1'b0;
    cyc(8);
    lnk2.sda_ctl_oe = 1'b0;
    cyc(8);
  endtask
  initial begin
    lnk2.scl_ctl_oe = 1'b0;
    lnk2.sda_ctl_oe = 1'b0;
    cyc(4);
    rst = 1'b0;
    check("hs_filter", 16'(hs_filter2), 16'h0000);
    check("busy", 16'(busy), 16'h0000);
    // ordinary transfers through the controller
    foreach (rows[k]) begin
      cmd_read = rows[k].rd;
      cmd_ptr = rows[k].ptr;
      cmd_wdata = rows[k].wd;
      cmd_valid = 1'b1;
      cyc(1);
      cmd_valid = 1'b0;
      for (int i = 0; i <= 4000 && done !== 1'b1; i++) begin
        if (i == 4000) begin
          check("done", 16'(done), 16'h0001);
          summarize();
        end
        cyc(1);
      end
      check("nacked", 16'(nacked), 16'h0000);
      if (rows[k].rd) check("rdata", 16'(rdata), {8'h00, rows[k].ptr ^ rd_key});
      else check("write", wq.pop_front(), {rows[k].ptr, rows[k].wd});
    end
    check("hs_filter", 16'(hs_filter), 16'h0000);
    // general call refused, the bytes after it ignored
    bb_start();
    bb_byte(8'h00, 1'b1, rv, ra);
    check("gc ack", 16'(ra), 16'h0001);
    bb_byte(8'h30, 1'b1, rv, ra);
    check("ignored ack", 16'(ra), 16'h0001);
    bb_stop();
    bb_start();
    bb_byte(8'h32, 1'b1, rv, ra);
    check("foreign ack", 16'(ra), 16'h0001);
    // master code, then a repeated start and a sequential write up to the pointer top
    bb_start();
    bb_byte(8'h0b, 1'b1, rv, ra);
    check("code ack", 16'(ra), 16'h0001);
    check("hs_filter", 16'(hs_filter2), 16'h0001);
    bb_start();
    check("hs_filter", 16'(hs_filter2), 16'h0001);
    bb_byte(8'h30, 1'b1, rv, ra);
    check("addr ack", 16'(ra), 16'h0000);
    bb_byte(8'hfe, 1'b1, rv, ra);
    check("ptr ack", 16'(ra), 16'h0000);
    bb_byte(8'h3c, 1'b1, rv, ra);
    check("data ack", 16'(ra), 16'h0000);
    bb_byte(8'hc3, 1'b1, rv, ra);
    check("last ack", 16'(ra), 16'h0000);
    check("write", wq2.pop_front(), 16'hfe3c);
    check("next write", wq2.pop_front(), 16'hffc3);
    bb_stop();
    cyc(8);
    check("hs_filter", 16'(hs_filter2), 16'h0000);
    // sequential read, ended by not-acknowledge
    bb_start();
    bb_byte(8'h30, 1'b1, rv, ra);
    bb_byte(8'h10, 1'b1, rv, ra);
    bb_start();
    bb_byte(8'h31, 1'b1, rv, ra);
    check("read addr ack", 16'(ra), 16'h0000);
    bb_byte(8'hff, 1'b0, rv, ra);
    check("read 1", 16'(rv), {8'h00, 8'h10 ^ rd_key});
    bb_byte(8'hff, 1'b1, rv, ra);
    check("read 2", 16'(rv), {8'h00, 8'h11 ^ rd_key});
    bb_stop();
    check("stray writes", 16'(wq.size() + wq2.size()), 16'h0000);
    summarize();
  end
endmodule // testbench
